// ==== rtl/frfhp_pkg.sv ====
package frfhp_pkg;
  // Register byte addresses
  localparam logic [7:0] ADDR_CTRL    = 8'h00;
  localparam logic [7:0] ADDR_STATUS  = 8'h04;
  localparam logic [7:0] ADDR_IRQ_ST  = 8'h08;
  localparam logic [7:0] ADDR_IRQ_MSK = 8'h0C;
  // Field positions in second_control_word
  localparam int POS_CHAN     = 0;
  localparam int POS_THR      = 2;
  localparam int POS_TYPE     = 4;
  localparam int POS_POL      = 5;
  localparam int POS_DIR      = 6;
  localparam int POS_CONT     = 8;
  localparam logic [8:0] CTRL_RESET = 9'h030;
  // Interrupt event bit positions
  localparam int EV_TRIG  = 0;
  localparam int EV_READ  = 1;
  localparam int EV_WRITE = 2;
  localparam int EV_RSVD  = 3;
  localparam int EV_NUM   = 4;
  // Pulse width when no conversion clock runs (single mode)
  localparam int CLK_PERIOD_NS = 10;
  localparam int SINGLE_PULSE_NS = 20;
  localparam int SINGLE_PULSE_CYC =
    (SINGLE_PULSE_NS / CLK_PERIOD_NS) < 1 ? 1 : SINGLE_PULSE_NS / CLK_PERIOD_NS;

  typedef struct packed {
    logic chip_select_low_active_n;
    logic chip_select_high_active;
    logic rd_n;
    logic wr_n;
  } frfhp_pins_type;

  typedef struct packed {
    logic       continuous;
    logic       dir_sel;
    logic       flag_pol;
    logic       flag_type;
    logic [1:0] threshold_sel;
    logic [1:0] chan_cnt_m1;
  } frfhp_ctrl_type;

  typedef enum logic [2:0] {
    ST_CHECK,
    ST_LEVEL,
    ST_WAIT_EDGE,
    ST_PULSE,
    ST_DRAIN
  } frfhp_state_type;

  // Threshold count from select code and channel count; zero means reserved
  function automatic logic [3:0] frfhp_thr(input logic [1:0] sel, input logic [1:0] ch);
    logic [3:0] v;
    v = 4'h0;
    case (sel)
      2'h0: v = 4'(ch) + 4'h1;
      2'h1: v = (ch == 2'h2) ? 4'h6 : (ch == 2'h3) ? 4'h8 : 4'h4;
      2'h2: v = (ch == 2'h2) ? 4'h9 : (ch == 2'h3) ? 4'hC : 4'h8;
      default: v = (ch == 2'h0) ? 4'hE : (ch == 2'h3) ? 4'h0 : 4'hC;
    endcase
    return v;
  endfunction
endpackage

// ==== rtl/frfhp_top.sv ====
`timescale 1ns/1ps
// Functional notes
// RULE1: Flag type bit 4 picks a static level (0) or a pulse (1).
// RULE2: Flag polarity bit 5 makes the flag active low (0) or active high (1).
// RULE3: The flag goes active as soon as the FIFO reaches the threshold count; a continuous-mode pulse waits for the next conversion clock rise.
// RULE4: In level form the flag drops at the start of the first threshold read.
// RULE5: The threshold is checked again only after threshold-count reads.
// RULE6: The host should choose level form in single conversion mode.
// RULE7: In continuous mode a pulse lasts half a conversion clock period.
// RULE8: No new pulse until the threshold-count values before the last one are read.
// RULE9: In direction-line mode the host holds the read input high.
// RULE10: An access starts when the last of both chip selects and the strobe is valid.
// RULE11: In write-strobe mode the read input is the FIFO read strobe.
// RULE12: Threshold count comes from the two-bit select and channel count; 4-channel top code reserved.
// RULE13: Direction-select bit 6 turns the write input into a read/write line and disables read.
// RULE14: In direction-line mode high means read and low means write.
module frfhp_top
  import frfhp_pkg::*;
#(
  parameter int LEVEL_W = 5
)(
  input  wire logic               ref_clk_in,
  input  wire logic               rst_in,
  input  wire frfhp_pins_type     host_pins_in,
  input  wire logic               conversion_clock_input_in,
  input  wire logic [LEVEL_W-1:0] fifo_level_in,
  input  wire logic [7:0]         reg_addr_in,
  input  wire logic [31:0]        reg_wdata_in,
  input  wire logic               reg_wr_in,
  input  wire logic               reg_rd_in,
  output logic [31:0]             reg_rdata_out,
  output logic                    sample_ready_flag_out,
  output logic                    fifo_pop_out,
  output logic                    data_oe_out,
  output logic                    ctrl_load_out,
  output logic                    irq_out
);

  // Registers
  frfhp_ctrl_type        ctrl_ff, nxt_ctrl;
  logic [EV_NUM-1:0]     irq_st_ff, nxt_irq_st;
  logic [EV_NUM-1:0]     irq_msk_ff, nxt_irq_msk;
  logic [31:0]           rdata_ff, nxt_rdata;
  frfhp_state_type       state_ff, nxt_state;
  logic [3:0]            rd_cnt_ff, nxt_rd_cnt;
  logic [3:0]            pw_cnt_ff, nxt_pw_cnt;
  logic                  active_ff, nxt_active;
  logic                  flag_ff, nxt_flag;
  logic                  conv_prev_ff;
  logic                  rd_int_ff, wr_int_ff;
  logic                  pop_ff, load_ff, irq_ff;

  // Decoded combinational terms
  logic                  cs_ok, rd_int, wr_int, rd_start, wr_start;
  logic                  conv_rise, conv_fall;
  logic [3:0]            thr;
  logic [EV_NUM-1:0]     events;
  logic                  trig_now;

  // Host strobe decode; last valid signal opens the access
  always_comb
  begin
    cs_ok = ~host_pins_in.chip_select_low_active_n
            & host_pins_in.chip_select_high_active;                    // [RULE10]
    if (ctrl_ff.dir_sel)
    begin
      // Read input is ignored here; the host ties it high
      rd_int = cs_ok & host_pins_in.wr_n;                              // [RULE13] [RULE14] [RULE9]
      wr_int = cs_ok & ~host_pins_in.wr_n;                             // [RULE14]
    end
    else
    begin
      rd_int = cs_ok & ~host_pins_in.rd_n & host_pins_in.wr_n;         // [RULE11]
      wr_int = cs_ok & ~host_pins_in.wr_n & host_pins_in.rd_n;         // [RULE11]
    end
    rd_start  = rd_int & ~rd_int_ff;                                   // [RULE10]
    wr_start  = wr_int & ~wr_int_ff;
    conv_rise = conversion_clock_input_in & ~conv_prev_ff;
    conv_fall = ~conversion_clock_input_in & conv_prev_ff;
    thr       = frfhp_thr(ctrl_ff.threshold_sel, ctrl_ff.chan_cnt_m1); // [RULE12]
    trig_now  = (thr != 4'h0) && (fifo_level_in >= LEVEL_W'(thr));     // [RULE3]
  end

  // Flag sequencer
  always_comb
  begin
    nxt_state  = state_ff;
    nxt_rd_cnt = rd_cnt_ff;
    nxt_pw_cnt = pw_cnt_ff;
    nxt_active = active_ff;
    // Reads count in every state but the check state
    if (state_ff != ST_CHECK && rd_start)
      nxt_rd_cnt = rd_cnt_ff + 4'h1;
    case (state_ff)
      ST_CHECK:
      begin
        nxt_rd_cnt = 4'h0;
        if (trig_now)
        begin
          if (!ctrl_ff.flag_type)
          begin
            nxt_state  = ST_LEVEL;                                     // [RULE1]
            nxt_active = 1'b1;                                         // [RULE3]
          end
          else if (ctrl_ff.continuous)
            nxt_state = ST_WAIT_EDGE;                                  // [RULE7]
          else
          begin
            nxt_state  = ST_PULSE;
            nxt_active = 1'b1;
            nxt_pw_cnt = 4'(SINGLE_PULSE_CYC);
          end
        end
      end
      ST_LEVEL:
      begin
        if (rd_start)
        begin
          nxt_active = 1'b0;                                           // [RULE4]
          nxt_state  = ST_DRAIN;
        end
      end
      ST_WAIT_EDGE:
      begin
        if (conv_rise)
        begin
          nxt_state  = ST_PULSE;
          nxt_active = 1'b1;
        end
      end
      ST_PULSE:
      begin
        // Continuous: high phase of the conversion clock is the pulse
        if (ctrl_ff.continuous ? conv_fall : (pw_cnt_ff <= 4'h1))
        begin
          nxt_active = 1'b0;                                           // [RULE7]
          nxt_state  = ST_DRAIN;
        end
        else
          nxt_pw_cnt = pw_cnt_ff - 4'h1;
      end
      default:
      begin
        if (nxt_rd_cnt >= thr)
          nxt_state = ST_CHECK;                                        // [RULE5] [RULE8]
      end
    endcase
    nxt_flag = nxt_active ~^ ctrl_ff.flag_pol;                         // [RULE2]
  end

  always_ff @(posedge ref_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      state_ff     <= ST_CHECK;
      rd_cnt_ff    <= 4'h0;
      pw_cnt_ff    <= 4'h0;
      active_ff    <= 1'b0;
      flag_ff      <= 1'b0;
      conv_prev_ff <= 1'b0;
      rd_int_ff    <= 1'b0;
      wr_int_ff    <= 1'b0;
    end
    else
    begin
      state_ff     <= nxt_state;
      rd_cnt_ff    <= nxt_rd_cnt;
      pw_cnt_ff    <= nxt_pw_cnt;
      active_ff    <= nxt_active;
      flag_ff      <= nxt_flag;
      conv_prev_ff <= conversion_clock_input_in;
      rd_int_ff    <= rd_int;
      wr_int_ff    <= wr_int;
    end
  end

  // Register port, events and interrupt
  always_comb
  begin
    events = '0;
    events[EV_TRIG]  = (state_ff == ST_CHECK) && trig_now;
    events[EV_READ]  = rd_start;
    events[EV_WRITE] = wr_start;
    events[EV_RSVD]  = (thr == 4'h0);
    nxt_ctrl    = ctrl_ff;
    nxt_irq_msk = irq_msk_ff;
    nxt_irq_st  = irq_st_ff;
    nxt_rdata   = 32'h0000_0000;
    if (reg_wr_in)
    begin
      if (reg_addr_in == ADDR_CTRL)
      begin
        nxt_ctrl.chan_cnt_m1   = reg_wdata_in[POS_CHAN +: 2];
        nxt_ctrl.threshold_sel = reg_wdata_in[POS_THR +: 2];
        nxt_ctrl.flag_type     = reg_wdata_in[POS_TYPE];
        nxt_ctrl.flag_pol      = reg_wdata_in[POS_POL];
        nxt_ctrl.dir_sel       = reg_wdata_in[POS_DIR];
        nxt_ctrl.continuous    = reg_wdata_in[POS_CONT];
      end
      else if (reg_addr_in == ADDR_IRQ_ST)
        nxt_irq_st = irq_st_ff & ~reg_wdata_in[EV_NUM-1:0];
      else if (reg_addr_in == ADDR_IRQ_MSK)
        nxt_irq_msk = reg_wdata_in[EV_NUM-1:0];
    end
    // Set wins over a clear in the same cycle
    nxt_irq_st = nxt_irq_st | events;
    if (reg_rd_in)
    begin
      if (reg_addr_in == ADDR_CTRL)
        nxt_rdata = {23'h0, ctrl_ff.continuous, 1'b0, ctrl_ff.dir_sel,
                     ctrl_ff.flag_pol, ctrl_ff.flag_type,
                     ctrl_ff.threshold_sel, ctrl_ff.chan_cnt_m1};
      else if (reg_addr_in == ADDR_STATUS)
        nxt_rdata = {12'h0, thr, 3'h0, 5'(fifo_level_in), rd_cnt_ff,
                     3'(state_ff), active_ff};
      else if (reg_addr_in == ADDR_IRQ_ST)
        nxt_rdata = {28'h0, irq_st_ff};
      else if (reg_addr_in == ADDR_IRQ_MSK)
        nxt_rdata = {28'h0, irq_msk_ff};
    end
  end

  always_ff @(posedge ref_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      // Fields picked from the register image; bit 7 has no storage
      ctrl_ff    <= '{continuous:    CTRL_RESET[POS_CONT],
                      dir_sel:       CTRL_RESET[POS_DIR],
                      flag_pol:      CTRL_RESET[POS_POL],
                      flag_type:     CTRL_RESET[POS_TYPE],
                      threshold_sel: CTRL_RESET[POS_THR +: 2],
                      chan_cnt_m1:   CTRL_RESET[POS_CHAN +: 2]};
      irq_st_ff  <= '0;
      irq_msk_ff <= '0;
      rdata_ff   <= 32'h0000_0000;
      pop_ff     <= 1'b0;
      load_ff    <= 1'b0;
      irq_ff     <= 1'b0;
    end
    else
    begin
      ctrl_ff    <= nxt_ctrl;
      irq_st_ff  <= nxt_irq_st;
      irq_msk_ff <= nxt_irq_msk;
      rdata_ff   <= nxt_rdata;
      pop_ff     <= rd_start;
      load_ff    <= wr_start;
      irq_ff     <= |(nxt_irq_st & nxt_irq_msk);
    end
  end

  assign reg_rdata_out         = rdata_ff;
  assign sample_ready_flag_out = flag_ff;
  assign fifo_pop_out          = pop_ff;
  assign data_oe_out           = rd_int_ff;
  assign ctrl_load_out         = load_ff;
  assign irq_out               = irq_ff;

  // Checks
  localparam int PW_MAX = 2;

  sequence s_trigger;
    state_ff == ST_CHECK && trig_now && !ctrl_ff.flag_type;
  endsequence

  sequence s_level_up;
    ##1 active_ff;
  endsequence

  chk_polarity_map: assert property (@(posedge ref_clk_in) disable iff (rst_in) // [RULE2]
    $past(ctrl_ff.flag_pol) == ctrl_ff.flag_pol |-> flag_ff == (active_ff ~^ ctrl_ff.flag_pol))
    else $error("flag level does not follow polarity");

  chk_level_set: assert property (@(posedge ref_clk_in) disable iff (rst_in) // [RULE3]
    s_trigger |-> s_level_up)
    else $error("flag not raised on threshold");

  chk_level_drop: assert property (@(posedge ref_clk_in) disable iff (rst_in) // [RULE4]
    state_ff == ST_LEVEL && rd_start |=> !active_ff && state_ff == ST_DRAIN)
    else $error("level flag kept after first read");

  chk_no_recheck: assert property (@(posedge ref_clk_in) disable iff (rst_in) // [RULE5]
    state_ff == ST_DRAIN && rd_cnt_ff < thr && !rd_start |=> state_ff == ST_DRAIN)
    else $error("threshold rechecked too early");

  chk_type_select: assert property (@(posedge ref_clk_in) disable iff (rst_in) // [RULE1]
    state_ff == ST_CHECK && trig_now && ctrl_ff.flag_type |=> state_ff != ST_LEVEL)
    else $error("pulse form entered level state");

  chk_pulse_end: assert property (@(posedge ref_clk_in) disable iff (rst_in) // [RULE7]
    state_ff == ST_PULSE && ctrl_ff.continuous && conv_fall |=> !active_ff)
    else $error("pulse outlived clock high phase");

  chk_single_pulse: assert property (@(posedge ref_clk_in) disable iff (rst_in) // [RULE8]
    state_ff == ST_PULSE && !ctrl_ff.continuous |-> ##[1:PW_MAX] state_ff == ST_DRAIN)
    else $error("single pulse too long");

  chk_drain_quiet: assert property (@(posedge ref_clk_in) disable iff (rst_in) // [RULE8]
    state_ff == ST_DRAIN |=> !active_ff)
    else $error("flag raised again before reads drained");

  chk_dir_read: assert property (@(posedge ref_clk_in) disable iff (rst_in) // [RULE13]
    ctrl_ff.dir_sel && !host_pins_in.wr_n |-> !rd_int)
    else $error("read taken with direction low");

  chk_pop_pulse: assert property (@(posedge ref_clk_in) disable iff (rst_in) // [RULE10]
    rd_start |=> fifo_pop_out ##1 !fifo_pop_out)
    else $error("pop not one cycle per access");

endmodule

// ==== sim/frfhp_host_model.sv ====
`timescale 1ns/1ps
// Host processor on the parallel port; chip selects always go valid last
module frfhp_host_model
  import frfhp_pkg::*;
(
  input  wire logic     clk_in,
  output frfhp_pins_type pins_out
);
  // Idle: both chip selects inactive, both strobes high
  initial pins_out = 4'hB;

  // One access; direction mode keeps the read input high throughout
  task automatic access(input logic is_rd, input logic dir);
    @(posedge clk_in);
    pins_out.rd_n <= dir | ~is_rd;
    pins_out.wr_n <= is_rd;
    @(posedge clk_in);
    pins_out.chip_select_low_active_n <= 1'b0;
    pins_out.chip_select_high_active  <= 1'b1;
    repeat (2) @(posedge clk_in);
    pins_out.chip_select_low_active_n <= 1'b1;
    pins_out.chip_select_high_active  <= 1'b0;
    @(posedge clk_in);
    pins_out.rd_n <= 1'b1;
    pins_out.wr_n <= 1'b1;
  endtask
endmodule

// ==== sim/frfhp_top_test.sv ====
`timescale 1ns/1ps
module frfhp_top_test;
  import frfhp_pkg::*;
  logic           clk, rst, conv, conv_en, wr, rd, flag, flag_q, pop, oe, load, irq;
  logic [4:0]     level;
  logic [2:0]     cdiv;
  logic [7:0]     addr;
  logic [31:0]    wdata, rdata, got;
  frfhp_pins_type pins;
  int             failures, checks, pops, loads, rises, highs, r0, h0, oes;
  // Expected threshold per select code (row) and channel count (column)
  logic [3:0]     thr_tab [4][4] = '{'{4'h1, 4'h2, 4'h3, 4'h4}, '{4'h4, 4'h4, 4'h6, 4'h8},
                                     '{4'h8, 4'h8, 4'h9, 4'hC}, '{4'hE, 4'hC, 4'hC, 4'h0}};

  frfhp_top u_frfhp_top (.ref_clk_in(clk), .rst_in(rst), .host_pins_in(pins),
    .conversion_clock_input_in(conv), .fifo_level_in(level), .reg_addr_in(addr),
    .reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata),
    .sample_ready_flag_out(flag), .fifo_pop_out(pop), .data_oe_out(oe),
    .ctrl_load_out(load), .irq_out(irq));

  frfhp_host_model u_frfhp_host_model (.clk_in(clk), .pins_out(pins));

  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Event counters; conversion clock of eight cycles, so a half period is four
  always @(posedge clk)
  begin
    pops   <= pops + int'(pop);
    loads  <= loads + int'(load);
    oes    <= oes + int'(oe);
    rises  <= rises + int'(flag & ~flag_q);
    highs  <= highs + int'(flag);
    flag_q <= flag;
    cdiv   <= cdiv + 3'h1;
    conv   <= conv_en & cdiv[2];
  end

  task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    wr    <= 1'b1;
    addr  <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic reg_read(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    rd   <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask

  task automatic check_word(input logic [31:0] g, input logic [31:0] e);
    checks++;
    if (g !== e)
    begin
      failures++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  // Flag sampled settled, after the edges have landed
  task automatic check_flag(input int n, input logic e);
    repeat (n) @(posedge clk);
    #1 check_word({31'h0, flag}, {31'h0, e});
  endtask

  task automatic final_report();
    $display("Checks %0d, failures %0d", checks, failures);
    if (failures == 0 && checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // Whole run is a few hundred cycles
  initial
  begin
    #200000;
    failures++;
    final_report();
  end

  initial
  begin
    {rst, conv_en, conv, wr, rd, flag_q, level, cdiv, addr, wdata} = '1;
    {conv_en, conv, wr, rd, flag_q, level, cdiv, addr, wdata} = '0;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    reg_read(ADDR_CTRL, got);
    check_word(got, 32'h030);
    check_word({31'h0, flag}, 32'h0);
    reg_read(8'h10, got);
    check_word(got, 32'h0);
    // Every select code against every channel count
    for (int s = 0; s < 4; s++)
      for (int c = 0; c < 4; c++)
      begin
        reg_write(ADDR_CTRL, 32'(s * 4 + c));
        reg_read(ADDR_STATUS, got);
        check_word({28'h0, got[19:16]}, {28'h0, thr_tab[s][c]});
      end
    // Level form, active high, threshold two, single conversion
    reg_write(ADDR_CTRL, 32'h021);
    reg_write(ADDR_IRQ_ST, 32'hF);
    reg_write(ADDR_IRQ_MSK, 32'h1);
    @(posedge clk);
    level <= 5'h2;
    check_flag(2, 1'b1);
    check_flag(6, 1'b1);
    u_frfhp_host_model.access(1'b1, 1'b0);
    check_flag(0, 1'b0);
    check_flag(5, 1'b0);
    u_frfhp_host_model.access(1'b1, 1'b0);
    check_flag(3, 1'b1);
    check_word(32'(pops), 32'h2);
    check_word({31'h0, irq}, 32'h1);
    reg_write(ADDR_IRQ_ST, 32'h1);
    check_flag(1, 1'b1);
    check_word({31'h0, irq}, 32'h0);
    // Active low while still active, then inactive high after a read
    reg_write(ADDR_CTRL, 32'h001);
    level <= 5'h0;
    check_flag(2, 1'b0);
    u_frfhp_host_model.access(1'b1, 1'b0);
    check_flag(1, 1'b1);
    u_frfhp_host_model.access(1'b0, 1'b0);
    // Direction mode: one write, one read through the combined line
    reg_write(ADDR_CTRL, 32'h061);
    u_frfhp_host_model.access(1'b0, 1'b1);
    u_frfhp_host_model.access(1'b1, 1'b1);
    check_flag(1, 1'b0);
    check_word(32'(loads), 32'h2);
    check_word(32'(pops), 32'h4);
    // Output enable stands two cycles for each of the four reads
    check_word(32'(oes), 32'h8);
    // Pulse form, continuous: one pulse only until two reads drain it
    reg_write(ADDR_CTRL, 32'h131);
    r0 = rises;
    h0 = highs;
    conv_en <= 1'b1;
    level   <= 5'h2;
    repeat (40) @(posedge clk);
    check_word(32'(rises - r0), 32'h1);
    check_word(32'(highs - h0), 32'h4);
    u_frfhp_host_model.access(1'b1, 1'b0);
    u_frfhp_host_model.access(1'b1, 1'b0);
    repeat (20) @(posedge clk);
    check_word(32'(rises - r0), 32'h2);
    // Pulse form, single conversion: fixed width, again only after two reads
    reg_write(ADDR_CTRL, 32'h031);
    r0 = rises;
    h0 = highs;
    u_frfhp_host_model.access(1'b1, 1'b0);
    u_frfhp_host_model.access(1'b1, 1'b0);
    repeat (10) @(posedge clk);
    check_word(32'(rises - r0), 32'h1);
    check_word(32'(highs - h0), 32'(SINGLE_PULSE_CYC));
    final_report();
  end
endmodule
